// ### nsms_regs.svh
/*
  Offsets, field positions, reset values and timing counts for the
  network station mode supervisor. Assumes a 25 MHz core clock.
*/
`ifndef NSMS_REGS_SVH
`define NSMS_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NSMS_OFF_CTRL 4'h0
`define NSMS_OFF_STATUS 4'h1
`define NSMS_OFF_RXDATA 4'h2
`define NSMS_OFF_LOST 4'h3
`define NSMS_OFF_PAUSE 4'h4
`define NSMS_OFF_BASE 4'h5

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define NSMS_CTRL_STATION_LSB 0
`define NSMS_CTRL_PAUSE_LSB 4
`define NSMS_CTRL_PUSH_BIT 8
`define NSMS_CTRL_FOLLOW_BIT 9
`define NSMS_CTRL_SLAVE_BIT 10
`define NSMS_CTRL_BAUD_LSB 12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NSMS_RST_STATION 4'h0
`define NSMS_RST_PAUSE 4'h0
`define NSMS_RST_PUSH 1'b1
`define NSMS_RST_FOLLOW 1'b1
`define NSMS_RST_SLAVE 1'b1
`define NSMS_RST_BAUD 3'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NSMS_CLK_HZ 25000000
`define NSMS_LOSS_MIN_MS 180
`define NSMS_LOSS_MAX_MS 9000

`endif

// ### nsms_pkg.sv
/*
  Types for the network station mode supervisor.
  Assumes the constants header is included by the design file.
*/
package nsms_pkg;
  typedef enum logic [1:0] {
    NSMS_IDLE,
    NSMS_BASE,
    NSMS_PAUSE
  } nsms_cycle_t;

  typedef enum logic [1:0] {
    NSMS_OFFLINE,
    NSMS_CONFIG,
    NSMS_ONLINE
  } nsms_link_t;
endpackage

// ### nsms_supervisor.sv
/*
  Network station mode supervisor: cycle pause timing, change push,
  run/stop following of station 1, sign-of-life watch.
  Assumes frame strobes from a same-clock link controller and async pins
  (io state, config running) from outside, which are synchronised here.
*/
// The placing of the registers and the strobed register port were chosen for this implementation.
// Function
// - cycle pause equals base pause times one plus multiplier n, n 0..15.
// - multiplier resets to zero.
// - all stations use one multiplier; station 1 may distribute it.
// - base pause is worked out by stations from pending messages; here it is written through the BASE register.
// - change push sends extra telegram on every io state change.
// - change push defaults on.
// - program-less station always pushes io changes.
// - stations 2..8 with follow enabled copy station 1 run/stop.
// - follow option unavailable on station 1.
// - program plus display follows only on status screen or text.
// - safety relay has no remote io slave mode.
// - entering a program leaves slave io mode for good.
// - slave io station exposes its io to station 1.
// - station number zero stays off network, refuses network config; it still takes station 1 data, and run/stop when follow is on.
// - configured stations stop while network configuration runs.
// - station 1 loss is found only by sign-of-life loss.
// - keep old data until loss detected, 180..9000 ms.
// - programmed follower on loss zeros data, keeps mode, sets flag.
// - program-less slave on loss zeros data, stops on status screen; with follow off run returns to local_run_in one clock later.
// - station number 1..8 unique; zero keeps unit off network.
// - bit rate selectable, default 125 kbaud, identical everywhere.
`include "nsms_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module nsms_supervisor #(
  parameter int IO_W = 16,
  parameter int DATA_W = 32,
  parameter logic SAFETY_DEVICE = 1'b1,
  parameter int LOSS_MS = 180,
  parameter int LOSS_CYCLES = (`NSMS_CLK_HZ / 1000) * LOSS_MS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [IO_W-1:0] io_state_in,
  input wire logic config_run_in,
  input wire logic has_program_in,
  input wire logic display_ok_in,
  input wire logic has_display_in,
  input wire logic local_run_in,
  input wire logic frame_valid_in,
  input wire logic [3:0] frame_src_in,
  input wire logic frame_is_mode_in,
  input wire logic frame_run_in,
  input wire logic frame_is_data_in,
  input wire logic [DATA_W-1:0] frame_data_in,
  input wire logic frame_is_config_in,
  input wire logic [3:0] frame_pause_in,
  input wire logic tx_done_in,
  output logic tx_cycle_out,
  output logic tx_push_out,
  output logic [IO_W-1:0] tx_io_out,
  output logic net_led_out,
  output logic run_out,
  output logic slave_io_out,
  output logic station1_lost_flag_out,
  output logic [DATA_W-1:0] rx_data_out
);

  localparam int LCW = $clog2(LOSS_CYCLES + 1);

  typedef struct packed {
    logic [3:0] station_number;
    logic [3:0] pause_mult;
    logic push_en;
    logic follow_en;
    logic slave_en;
    logic [2:0] baud;
    logic [15:0] base_pause_time;
    logic [19:0] pause_cnt;
    nsms_pkg::nsms_cycle_t cyc;
    nsms_pkg::nsms_link_t link;
    logic [IO_W-1:0] io_s1;
    logic [IO_W-1:0] io_s2;
    logic [IO_W-1:0] io_last;
    logic cfg_s1;
    logic cfg_s2;
    logic [LCW-1:0] life_cnt;
    logic lost;
    logic [7:0] station_lost_flags;
    logic [DATA_W-1:0] rx_data;
    logic run;
    logic tx_cycle;
    logic tx_push;
    logic [31:0] rdata;
  } nsms_state_t;

  nsms_state_t s_reg, s_next;

  logic is_station1;
  logic program_less;
  logic pushing;

  always_comb begin
    s_next = s_reg;
    is_station1 = (s_reg.station_number == 4'h1);
    program_less = ~has_program_in;
    pushing = 1'b0;
    s_next.tx_cycle = 1'b0;
    s_next.tx_push = 1'b0;
    s_next.rdata = 32'h0000_0000;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    s_next.io_s1 = io_state_in;
    s_next.io_s2 = s_reg.io_s1;
    s_next.cfg_s1 = config_run_in;
    s_next.cfg_s2 = s_reg.cfg_s1;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr_in) begin
      case (addr_in)
        `NSMS_OFF_CTRL: begin
          if (wdata_in[`NSMS_CTRL_STATION_LSB +: 4] <= 4'h8) begin
            s_next.station_number = wdata_in[`NSMS_CTRL_STATION_LSB +: 4];
          end
          s_next.pause_mult = wdata_in[`NSMS_CTRL_PAUSE_LSB +: 4];
          s_next.push_en = wdata_in[`NSMS_CTRL_PUSH_BIT];
          s_next.follow_en = wdata_in[`NSMS_CTRL_FOLLOW_BIT];
          s_next.slave_en = s_reg.slave_en & wdata_in[`NSMS_CTRL_SLAVE_BIT] & ~SAFETY_DEVICE;
          if (wdata_in[`NSMS_CTRL_BAUD_LSB +: 3] <= 3'h6) begin
            s_next.baud = wdata_in[`NSMS_CTRL_BAUD_LSB +: 3];
          end
        end
        `NSMS_OFF_BASE: s_next.base_pause_time = wdata_in[15:0];
        default: begin
        end
      endcase
    end

    if (has_program_in) begin
      s_next.slave_en = 1'b0;
    end

    // ----------------------------------------------------------------
    // network membership
    // ----------------------------------------------------------------
    // unnumbered unit stays off
    if (s_reg.station_number == 4'h0) begin
      s_next.link = nsms_pkg::NSMS_OFFLINE;
    end else if (s_reg.cfg_s2) begin
      s_next.link = nsms_pkg::NSMS_CONFIG;
      s_next.run = 1'b0;
    end else begin
      s_next.link = nsms_pkg::NSMS_ONLINE;
    end

    if (frame_valid_in && frame_is_config_in && frame_src_in == 4'h1 &&
        s_reg.station_number != 4'h0 && !is_station1) begin
      s_next.pause_mult = frame_pause_in;
    end

    // ----------------------------------------------------------------
    // cycle pause timer
    // ----------------------------------------------------------------
    case (s_reg.cyc)
      nsms_pkg::NSMS_IDLE: begin
        // one start pulse per cycle, then wait for the link to finish it
        if (s_reg.link == nsms_pkg::NSMS_ONLINE) begin
          s_next.tx_cycle = 1'b1;
          s_next.cyc = nsms_pkg::NSMS_BASE;
        end
      end
      nsms_pkg::NSMS_BASE: begin
        if (tx_done_in) begin
          s_next.cyc = nsms_pkg::NSMS_PAUSE;
          s_next.pause_cnt = 20'(s_reg.base_pause_time) * 20'({1'b0, s_reg.pause_mult} + 5'h01);
        end else if (s_reg.link != nsms_pkg::NSMS_ONLINE) begin
          s_next.cyc = nsms_pkg::NSMS_IDLE;
        end
      end
      nsms_pkg::NSMS_PAUSE: begin
        if (s_reg.pause_cnt <= 20'h0_0001) begin
          s_next.cyc = nsms_pkg::NSMS_IDLE;
        end else begin
          s_next.pause_cnt = s_reg.pause_cnt - 20'h0_0001;
        end
      end
      default: s_next.cyc = nsms_pkg::NSMS_IDLE;
    endcase

    // ----------------------------------------------------------------
    // change push
    // ----------------------------------------------------------------
    // push on change
    pushing = (s_reg.io_s2 != s_reg.io_last) && (s_reg.push_en || program_less);
    s_next.io_last = s_reg.io_s2;
    if (pushing && s_reg.link == nsms_pkg::NSMS_ONLINE) begin
      s_next.tx_push = 1'b1;
    end

    // ----------------------------------------------------------------
    // local run/stop and station 1 following
    // ----------------------------------------------------------------
    if (s_reg.link != nsms_pkg::NSMS_CONFIG) begin
      if (is_station1 || !s_reg.follow_en) begin
        s_next.run = local_run_in;
      end else if (frame_valid_in && frame_is_mode_in && frame_src_in == 4'h1) begin
        if (program_less || !has_display_in || display_ok_in) begin
          s_next.run = frame_run_in;
        end
      end
    end

    // ----------------------------------------------------------------
    // sign of life
    // ----------------------------------------------------------------
    if (frame_valid_in && frame_src_in == 4'h1) begin
      s_next.life_cnt = '0;
      s_next.lost = 1'b0;
      if (frame_is_data_in) begin
        s_next.rx_data = frame_data_in;
      end
    end else if (!is_station1 && s_reg.link == nsms_pkg::NSMS_ONLINE && !s_reg.lost) begin
      if (s_reg.life_cnt == LCW'(LOSS_CYCLES - 1)) begin
        s_next.lost = 1'b1;
        s_next.rx_data = '0;
        if (s_reg.slave_en && program_less && display_ok_in) begin
          s_next.run = 1'b0;
        end
      end else begin
        s_next.life_cnt = s_reg.life_cnt + LCW'(1);
      end
    end
    s_next.station_lost_flags[0] = s_next.lost;

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    if (rd_in) begin
      case (addr_in)
        `NSMS_OFF_CTRL: s_next.rdata = {17'h0_0000, s_reg.baud, 1'b0, s_reg.slave_en,
                                        s_reg.follow_en, s_reg.push_en, s_reg.pause_mult,
                                        s_reg.station_number};
        `NSMS_OFF_STATUS: s_next.rdata = {26'h000_0000, s_reg.link, s_reg.cyc, s_reg.lost, s_reg.run};
        `NSMS_OFF_RXDATA: s_next.rdata = 32'(s_reg.rx_data);
        `NSMS_OFF_LOST: s_next.rdata = {24'h00_0000, s_reg.station_lost_flags};
        `NSMS_OFF_PAUSE: s_next.rdata = {12'h000, s_reg.pause_cnt};
        `NSMS_OFF_BASE: s_next.rdata = {16'h0000, s_reg.base_pause_time};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_reg <= '0;
      s_reg.station_number <= `NSMS_RST_STATION;
      s_reg.pause_mult <= `NSMS_RST_PAUSE;
      s_reg.push_en <= `NSMS_RST_PUSH;
      s_reg.follow_en <= `NSMS_RST_FOLLOW;
      s_reg.slave_en <= `NSMS_RST_SLAVE & ~SAFETY_DEVICE;
      s_reg.baud <= `NSMS_RST_BAUD;
      s_reg.cyc <= nsms_pkg::NSMS_IDLE;
      s_reg.link <= nsms_pkg::NSMS_OFFLINE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign tx_cycle_out = s_reg.tx_cycle;
  assign tx_push_out = s_reg.tx_push;
  assign tx_io_out = s_reg.io_last;
  assign net_led_out = (s_reg.link == nsms_pkg::NSMS_ONLINE);
  assign run_out = s_reg.run;
  assign slave_io_out = s_reg.slave_en;
  assign station1_lost_flag_out = s_reg.lost;
  assign rx_data_out = s_reg.rx_data;

endmodule // nsms_supervisor

`default_nettype wire

// ### nsms_chk.sv
/*
  Port checker for nsms_supervisor.
  Assumes it is bound to the supervisor and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module nsms_chk #(
  parameter int IO_W = 16,
  parameter int DATA_W = 32,
  parameter int LOSS_CYCLES = 20
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic rd_in,
  input wire logic [IO_W-1:0] io_state_in,
  input wire logic config_run_in,
  input wire logic frame_valid_in,
  input wire logic [3:0] frame_src_in,
  input wire logic tx_cycle_out,
  input wire logic tx_push_out,
  input wire logic run_out,
  input wire logic slave_io_out,
  input wire logic station1_lost_flag_out,
  input wire logic [DATA_W-1:0] rx_data_out,
  input wire logic [31:0] rdata_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic [15:0] quiet_reg;
  logic [3:0] since_io_reg;
  logic [IO_W-1:0] io_d_reg;
  wire logic f1 = frame_valid_in && frame_src_in == 4'h1;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      quiet_reg <= '0;
      since_io_reg <= 4'hf;
      io_d_reg <= '0;
    end else begin
      io_d_reg <= io_state_in;
      quiet_reg <= f1 ? 16'h0000 : quiet_reg + {15'h0000, quiet_reg != 16'hffff};
      since_io_reg <= (io_d_reg != io_state_in) ? 4'h0 : since_io_reg + {3'h0, since_io_reg != 4'hf};
    end
  end
  rd_idle_zero_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  cycle_pulse_a: assert property (tx_cycle_out |=> !tx_cycle_out)
    else $error("cycle start longer than one clock");
  push_pulse_a: assert property (tx_push_out |=> !tx_push_out)
    else $error("push telegram longer than one clock");
  push_cause_a: assert property (tx_push_out |-> since_io_reg <= 4'h8)
    else $error("push telegram without an io change");
  loss_zero_a: assert property ($rose(station1_lost_flag_out) |-> ##[0:1] rx_data_out == '0)
    else $error("received data kept after loss");
  loss_time_a: assert property ($rose(station1_lost_flag_out) |-> quiet_reg >= LOSS_CYCLES - 1)
    else $error("loss flagged too early");
  loss_clear_a: assert property (f1 |-> ##[1:2] !station1_lost_flag_out)
    else $error("lost flag not cleared by frame");
  no_slave_a: assert property (!slave_io_out)
    else $error("slave io mode on a safety device");
  cfg_stop_a: assert property (config_run_in [*5] |-> !run_out)
    else $error("running during network configuration");
endmodule // nsms_chk
`default_nettype wire

// ### nsms_peer.sv
/*
  Model of the other stations: station 1 sign of life with mode and data,
  and the link controller's end-of-transfer answer.
  Assumes one clock shared with the supervisor.
*/
`timescale 1ns/100ps
`default_nettype none
module nsms_peer (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic alive_in,
  input wire logic run_in,
  input wire logic [31:0] data_in,
  input wire logic tx_cycle_in,
  output logic frame_valid_out,
  output logic [3:0] frame_src_out,
  output logic frame_run_out,
  output logic [31:0] frame_data_out,
  output logic tx_done_out
);
  logic [2:0] tick_reg;
  logic [1:0] ack_reg;
  logic [31:0] pat_reg;
  // same rate and multiplier, nothing sent to change them
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_reg <= 3'h0;
      ack_reg <= 2'h0;
      pat_reg <= 32'h0000_0000;
      frame_valid_out <= 1'b0;
      tx_done_out <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 3'h1;
      pat_reg <= pat_reg + 32'h9e37_79b9;
      frame_valid_out <= alive_in && tick_reg == 3'h7;
      ack_reg <= tx_cycle_in ? 2'h3 : ack_reg - {1'b0, ack_reg != 2'h0};
      tx_done_out <= ack_reg == 2'h1;
    end
  end
  // idle fields keep moving so a stale value is never mistaken for data
  assign frame_src_out = frame_valid_out ? 4'h1 : pat_reg[3:0];
  assign frame_run_out = frame_valid_out ? run_in : pat_reg[4];
  assign frame_data_out = frame_valid_out ? data_in : pat_reg;
endmodule // nsms_peer
`default_nettype wire

// ### nsms_supervisor_test.sv
/*
  Self-checking bench for nsms_supervisor with the peer model.
  Assumes a shortened loss timeout for simulation.
*/
`timescale 1ns/100ps
`default_nettype none
module nsms_supervisor_test;
  localparam int LOSS = 20;
  logic clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, cfg = 0, prog = 0, disp_ok = 0, disp = 0, lrun = 0;
  logic alive = 1, prun = 0, pend = 0, fv, frun, tdone, txc, txp, led, run, slv, lost, s;
  logic [3:0] addr = 4'h0, src;
  logic [31:0] wdata = 0, pdata = 0, fdata, rdata, rxd, rnd = 32'h0000_95fb, e, n;
  logic [15:0] io = 16'h0000, txio;
  logic [31:0] q[$];
  int n_mismatch = 0, compares = 0, cyc = 0, g;
  always #20 clk_in = ~clk_in;
  nsms_supervisor #(.LOSS_CYCLES(LOSS)) i_dut (.clk_in, .reset_in, .addr_in(addr), .wdata_in(wdata),
    .wr_in, .rd_in, .rdata_out(rdata), .io_state_in(io), .config_run_in(cfg), .has_program_in(prog),
    .display_ok_in(disp_ok), .has_display_in(disp), .local_run_in(lrun), .frame_valid_in(fv),
    .frame_src_in(src), .frame_is_mode_in(fv), .frame_run_in(frun), .frame_is_data_in(fv),
    .frame_data_in(fdata), .frame_is_config_in(1'b0), .frame_pause_in(4'h0), .tx_done_in(tdone),
    .tx_cycle_out(txc), .tx_push_out(txp), .tx_io_out(txio), .net_led_out(led), .run_out(run),
    .slave_io_out(slv), .station1_lost_flag_out(lost), .rx_data_out(rxd));
  nsms_peer i_peer (.clk_in, .reset_in, .alive_in(alive), .run_in(prun), .data_in(pdata),
    .tx_cycle_in(txc), .frame_valid_out(fv), .frame_src_out(src), .frame_run_out(frun),
    .frame_data_out(fdata), .tx_done_out(tdone));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    compares++;
    if (x !== y) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, x, y);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a; wdata <= d; wr_in <= 1;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk_in);
    addr <= a; rd_in <= 1; q.push_back(x);
    @(posedge clk_in);
    rd_in <= 0;
  endtask
  task idle(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task gap(output int c);
    c = 0;
    for (int i = 0; i < 300 && tdone !== 1'b1; i++) @(negedge clk_in);
    for (c = 0; c < 300 && txc !== 1'b1; c++) @(negedge clk_in);
  endtask
  task push_seen(output logic p);
    p = 0;
    rnd = lfsr(rnd);
    @(posedge clk_in) io <= rnd[15:0];
    repeat (12) @(negedge clk_in) if (txp === 1'b1) p = 1;
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (pend) begin
      e = q.pop_front();
      chk("rdata", e, rdata);
    end
    pend = rd_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 0;
    rd(4'h0, 32'h0000_3300);
    rd(4'hf, 32'h0000_0000);
    idle(30);
    chk("net_led", 0, led);
    wr(4'h0, 32'h0000_7309);
    rd(4'h0, 32'h0000_3300);
    $display("test defaults done");
    wr(4'h5, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      n = (i == 0) ? 0 : (i == 1) ? 15 : {28'h0, rnd[3:0]};
      wr(4'h0, 32'h0000_3302 | (n << 4));
      rd(4'h0, 32'h0000_3302 | (n << 4));
      gap(g);
      gap(g);
      e = 4 * (1 + n);
      chk("pause_gap", e, (g >= e && g <= e + 4) ? e : g);
    end
    $display("test pause done");
    push_seen(s);
    chk("push_on", 1, s);
    chk("push_io", {16'h0, io}, {16'h0, txio});
    prog <= 1;
    wr(4'h0, 32'h0000_3202);
    push_seen(s);
    chk("push_off", 0, s);
    prog <= 0;
    push_seen(s);
    chk("push_noprog", 1, s);
    $display("test push done");
    prun <= 1;
    idle(20);
    chk("follow_run", 1, run);
    prun <= 0;
    idle(20);
    chk("follow_stop", 0, run);
    prog <= 1; disp <= 1; disp_ok <= 0; prun <= 1;
    idle(20);
    chk("follow_menu", 0, run);
    disp_ok <= 1;
    idle(20);
    chk("follow_status", 1, run);
    $display("test follow done");
    rnd = lfsr(rnd);
    pdata <= rnd;
    idle(20);
    chk("rx_data", pdata, rxd);
    alive <= 0;
    idle(8);
    chk("rx_kept", pdata, rxd);
    idle(LOSS + 12);
    chk("lost", 1, lost);
    chk("rx_zero", 0, rxd);
    chk("mode_kept", 1, run);
    alive <= 1;
    idle(20);
    chk("lost_clear", 0, lost);
    $display("test loss done");
    wr(4'h0, 32'h0000_3301);
    prun <= 1; lrun <= 0;
    idle(20);
    chk("st1_local", 0, run);
    lrun <= 1;
    idle(20);
    chk("st1_run", 1, run);
    cfg <= 1;
    idle(10);
    chk("cfg_stop", 0, run);
    cfg <= 0;
    $display("test station one done");
    tally_and_finish();
  end
endmodule // nsms_supervisor_test
bind nsms_supervisor nsms_chk #(.IO_W(IO_W), .DATA_W(DATA_W), .LOSS_CYCLES(LOSS_CYCLES)) i_chk (.clk_in,
  .reset_in, .rd_in, .io_state_in, .config_run_in, .frame_valid_in, .frame_src_in, .tx_cycle_out,
  .tx_push_out, .run_out, .slave_io_out, .station1_lost_flag_out, .rx_data_out, .rdata_out);
`default_nettype wire
